// ==== hw/utd_pkg.sv ====
// Shared constants and types of the upstream channel parameter decoder.
package utd_pkg;
  localparam logic [7:0] T_RATE = 8'h01;
  localparam logic [7:0] T_FREQ = 8'h02;
  localparam logic [7:0] T_PRE = 8'h03;
  localparam logic [7:0] T_BURST1 = 8'h04;
  localparam logic [7:0] T_BURST2 = 8'h05;
  localparam logic [7:0] T_PRE_EXT = 8'h06;
  localparam logic [7:0] T_MODE = 8'h07;
  localparam logic [7:0] T_FRAME = 8'h08;
  localparam logic [7:0] T_CPM = 8'h09;
  localparam logic [7:0] T_ACT = 8'h0A;
  localparam logic [7:0] T_SEED = 8'h0B;
  localparam logic [7:0] L_ONE = 8'h01;
  localparam logic [7:0] L_FREQ = 8'h04;
  localparam logic [7:0] L_SEED = 8'h02;
  localparam logic [7:0] PRE_MAX = 8'h80;
  localparam logic [7:0] EXT_MAX = 8'h40;
  localparam int PRE_BYTES = 192;
  localparam logic [7:0] MODE_ON = 8'h01;
  localparam logic [7:0] MODE_OFF = 8'h02;
  localparam logic [7:0] RATE_GEN2 = 8'h20;
  localparam logic [7:0] RATE_CDMA_MIN = 8'h08;
  localparam logic [7:0] FRAME_MIN = 8'h01;
  localparam logic [7:0] FRAME_MAX = 8'h20;
  localparam logic [7:0] CPM_MIN = 8'h02;
  localparam logic [7:0] CPM_MAX = 8'h20;
  localparam logic [7:0] ACT_MIN = 8'h40;
  localparam logic [7:0] ACT_MAX = 8'h80;
  localparam logic [8:0] A_CTRL = 9'h000;
  localparam logic [8:0] A_STATUS = 9'h004;
  localparam logic [8:0] A_RATE = 9'h008;
  localparam logic [8:0] A_FREQ = 9'h00C;
  localparam logic [8:0] A_CDMA = 9'h010;
  localparam logic [8:0] A_SEED = 9'h014;
  localparam logic [8:0] A_ERR = 9'h018;
  localparam logic [8:0] A_PRE = 9'h100;
  localparam logic [8:0] A_PRE_END = 9'h1C0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int E_LEN = 0;
  localparam int E_RANGE = 1;
  localparam int E_RATE = 2;
  localparam int E_MULT = 3;
  localparam int E_PRES = 4;
  localparam int E_ORDER = 5;
  localparam int E_TRUNC = 6;
  localparam int ERR_W = 7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {S_TYPE = 2'b00, S_LEN = 2'b01, S_VAL = 2'b10} utd_state_e;
endpackage : utd_pkg

// ==== hw/utd_decoder.sv ====
// Channel parameter decoder with preamble store and AXI4-Lite register access.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R01: Each parameter is one type byte, one length byte, then that many value bytes.
// R02: Type 1, one byte, is rate multiple of 160 kHz: 1,2,4,8,16,32.
// R03: Rate multiple 32 marks the channel as second-generation only.
// R04: Sender keeps rate at 8, 16 or 32 in code-division mode; others flagged.
// R05: Type 2, four bytes, is centre frequency in hertz.
// R06: Type 3, 1 to 128 bytes, is the first or whole preamble superstring.
// R07: Superstring bits run MSB first, eight per value byte.
// R08: Burst preambles are substrings of the stored superstring.
// R09: Types 4 and 5 are burst descriptors and may repeat.
// R10: Type 6, 1 to 64 bytes, extends the superstring after type 3.
// R11: Sender sends the extension only after a 128-byte base preamble.
// R12: Type 7, one byte: 1 selects code-division, 2 selects time-division.
// R13: Code-division on marks the channel as second-generation only.
// R14: Without type 7 the channel runs time-division.
// R15: Type 8, one byte, spreading intervals per frame, 1 to 32.
// R16: Type 9, one byte, codes per mini-slot, 2 to 32.
// R17: Type 10, one byte, active codes, 64 to 128.
// R18: Active codes must be a multiple of codes per mini-slot; else flagged.
// R19: Type 11 seed is 15 bits left-justified in two bytes.
// R20: Zero seed disables code hopping; otherwise hopping uses the seed.
// R21: Types 8 to 11 present exactly when code-division is on; mismatch flagged.
// R22: Burst descriptors come after all channel-wide parameters.
// R23: Unknown types are skipped by their length, leaving decoded values alone.
// R24: Wrong fixed length or out-of-range value sets a sticky error.
module utd_decoder (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic strm_valid_in,
  input wire logic [7:0] strm_data_in,
  input wire logic strm_first_in,
  input wire logic strm_last_in,
  output logic strm_ready_out,
  output logic msg_done_out,
  output logic gen2_only_out,
  output logic sync_cdma_out,
  output logic hopping_on_out,
  output logic error_out,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [8:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [8:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out
);
  utd_pkg::utd_state_e state_reg, cur_st;
  logic [7:0] type_reg, len_reg, cnt_reg;
  logic skip_reg;
  logic [7:0] rate_reg, frame_reg, cpm_reg, act_reg, pre_len_reg, ext_len_reg, b1_cnt_reg, b2_cnt_reg, tot_len;
  logic [31:0] freq_reg;
  logic [15:0] seed_raw_reg;
  logic cdma_reg, burst_seen_reg, en_reg;
  logic [3:0] seen_reg;
  logic [utd_pkg::ERR_W-1:0] err_reg, err_set, err_clr;
  logic done_pend_reg, done_reg, gen2_reg, hop_reg;
  logic [7:0] pre_mem [0:utd_pkg::PRE_BYTES-1];
  logic take, is_len, is_val, wr_val, last_val, msg_end, len_ok, wr_fire, ar_fire;
  logic [8:0] aw_word, ar_word;
  logic [31:0] rd_word;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_rng

  function automatic logic rate_ok(input logic [7:0] v);
    return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00) && (v <= utd_pkg::RATE_GEN2);
  endfunction : rate_ok

  function automatic logic mapped(input logic [8:0] a);
    return (a <= utd_pkg::A_ERR) || ((a >= utd_pkg::A_PRE) && (a < utd_pkg::A_PRE_END));
  endfunction : mapped

  function automatic logic [7:0] pre_byte(input logic [7:0] i);
    return (i < tot_len) ? pre_mem[i] : 8'h00;
  endfunction : pre_byte

  // Ready is software's stall: clearing the enable holds the stream source off.
  assign strm_ready_out = en_reg;
  assign take = strm_valid_in && en_reg;
  assign is_len = take && (cur_st == utd_pkg::S_LEN);
  assign is_val = take && (cur_st == utd_pkg::S_VAL);
  assign last_val = is_val && (cnt_reg == len_reg - 8'h01);
  assign wr_val = is_val && !skip_reg;
  assign msg_end = take && strm_last_in;
  assign tot_len = pre_len_reg + ext_len_reg;

  always_comb begin
    cur_st = strm_first_in ? utd_pkg::S_TYPE : state_reg;
  end

  always_comb begin
    case (type_reg)
      utd_pkg::T_RATE, utd_pkg::T_MODE, utd_pkg::T_FRAME, utd_pkg::T_CPM, utd_pkg::T_ACT: begin
        len_ok = (strm_data_in == utd_pkg::L_ONE);
      end
      utd_pkg::T_FREQ: len_ok = (strm_data_in == utd_pkg::L_FREQ);
      utd_pkg::T_SEED: len_ok = (strm_data_in == utd_pkg::L_SEED);
      utd_pkg::T_PRE: len_ok = in_rng(strm_data_in, utd_pkg::L_ONE, utd_pkg::PRE_MAX); // R06
      utd_pkg::T_PRE_EXT: begin
        len_ok = in_rng(strm_data_in, utd_pkg::L_ONE, utd_pkg::EXT_MAX) && (pre_len_reg == utd_pkg::PRE_MAX); // R10 R11
      end
      default: len_ok = 1'b1;
    endcase
  end

  // Type, length, value walk; a zero length goes straight back to a type byte.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_reg <= utd_pkg::S_TYPE;
      type_reg <= 8'h00;
      len_reg <= 8'h00;
      cnt_reg <= 8'h00;
      skip_reg <= 1'b0;
    end else if (take) begin
      unique case (cur_st)
        utd_pkg::S_TYPE: begin
          type_reg <= strm_data_in; // R01
          state_reg <= utd_pkg::S_LEN;
        end
        utd_pkg::S_LEN: begin
          len_reg <= strm_data_in; // R01
          cnt_reg <= 8'h00;
          skip_reg <= !len_ok; // R23 R24
          state_reg <= (strm_data_in == 8'h00) ? utd_pkg::S_TYPE : utd_pkg::S_VAL;
        end
        utd_pkg::S_VAL: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (last_val) begin
            state_reg <= utd_pkg::S_TYPE;
          end
        end
        default: state_reg <= utd_pkg::S_TYPE;
      endcase
    end
  end

  // Decoded parameters; a new message starts from defaults, so mode falls back to time-division.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || (take && strm_first_in)) begin
      rate_reg <= 8'h00;
      freq_reg <= 32'h0000_0000;
      cdma_reg <= 1'b0; // R14
      frame_reg <= 8'h00;
      cpm_reg <= 8'h00;
      act_reg <= 8'h00;
      seed_raw_reg <= 16'h0000;
      seen_reg <= 4'h0;
      pre_len_reg <= 8'h00;
      ext_len_reg <= 8'h00;
      b1_cnt_reg <= 8'h00;
      b2_cnt_reg <= 8'h00;
      burst_seen_reg <= 1'b0;
    end else begin
      if (is_len && (type_reg == utd_pkg::T_BURST1)) begin
        b1_cnt_reg <= b1_cnt_reg + 8'h01; // R09
        burst_seen_reg <= 1'b1;
      end
      if (is_len && (type_reg == utd_pkg::T_BURST2)) begin
        b2_cnt_reg <= b2_cnt_reg + 8'h01; // R09
        burst_seen_reg <= 1'b1;
      end
      if (wr_val) begin
        case (type_reg)
          utd_pkg::T_RATE: if (rate_ok(strm_data_in)) rate_reg <= strm_data_in; // R02
          utd_pkg::T_FREQ: freq_reg <= {freq_reg[23:0], strm_data_in}; // R05
          utd_pkg::T_PRE: pre_len_reg <= cnt_reg + 8'h01; // R06
          utd_pkg::T_PRE_EXT: ext_len_reg <= cnt_reg + 8'h01; // R10
          utd_pkg::T_MODE: begin
            if (strm_data_in == utd_pkg::MODE_ON) cdma_reg <= 1'b1; // R12
            else if (strm_data_in == utd_pkg::MODE_OFF) cdma_reg <= 1'b0; // R12
          end
          utd_pkg::T_FRAME: begin
            if (in_rng(strm_data_in, utd_pkg::FRAME_MIN, utd_pkg::FRAME_MAX)) frame_reg <= strm_data_in; // R15
            seen_reg[0] <= 1'b1;
          end
          utd_pkg::T_CPM: begin
            if (in_rng(strm_data_in, utd_pkg::CPM_MIN, utd_pkg::CPM_MAX)) cpm_reg <= strm_data_in; // R16
            seen_reg[1] <= 1'b1;
          end
          utd_pkg::T_ACT: begin
            if (in_rng(strm_data_in, utd_pkg::ACT_MIN, utd_pkg::ACT_MAX)) act_reg <= strm_data_in; // R17
            seen_reg[2] <= 1'b1;
          end
          utd_pkg::T_SEED: begin
            seed_raw_reg <= {seed_raw_reg[7:0], strm_data_in}; // R19
            seen_reg[3] <= 1'b1;
          end
          default: ; // R23
        endcase
      end
    end
  end

  // Extension bytes land right behind byte 128, so the store is one contiguous superstring.
  always_ff @(posedge clk_sys_in) begin
    if (wr_val && (type_reg == utd_pkg::T_PRE)) begin
      pre_mem[cnt_reg] <= strm_data_in; // R07
    end else if (wr_val && (type_reg == utd_pkg::T_PRE_EXT)) begin
      pre_mem[8'(utd_pkg::PRE_MAX + cnt_reg)] <= strm_data_in; // R10
    end
  end

  always_comb begin
    err_set = '0;
    if (is_len && !len_ok) err_set[utd_pkg::E_LEN] = 1'b1; // R24 R11
    if (wr_val) begin
      case (type_reg)
        utd_pkg::T_RATE: err_set[utd_pkg::E_RANGE] = !rate_ok(strm_data_in); // R24
        utd_pkg::T_MODE: begin
          err_set[utd_pkg::E_RANGE] = (strm_data_in != utd_pkg::MODE_ON) && (strm_data_in != utd_pkg::MODE_OFF);
        end
        utd_pkg::T_FRAME: err_set[utd_pkg::E_RANGE] = !in_rng(strm_data_in, utd_pkg::FRAME_MIN, utd_pkg::FRAME_MAX);
        utd_pkg::T_CPM: err_set[utd_pkg::E_RANGE] = !in_rng(strm_data_in, utd_pkg::CPM_MIN, utd_pkg::CPM_MAX);
        utd_pkg::T_ACT: err_set[utd_pkg::E_RANGE] = !in_rng(strm_data_in, utd_pkg::ACT_MIN, utd_pkg::ACT_MAX);
        default: ;
      endcase
    end
    if (take && (cur_st == utd_pkg::S_TYPE) && burst_seen_reg && !strm_first_in &&
        (in_rng(strm_data_in, utd_pkg::T_RATE, utd_pkg::T_PRE) || in_rng(strm_data_in, utd_pkg::T_PRE_EXT, utd_pkg::T_SEED))) begin
      err_set[utd_pkg::E_ORDER] = 1'b1; // R22
    end
    if (msg_end && !((is_len && (strm_data_in == 8'h00)) || last_val)) err_set[utd_pkg::E_TRUNC] = 1'b1;
    // Whole-message checks wait one cycle so the last byte's value is already stored.
    if (done_pend_reg) begin
      if (cdma_reg) begin
        err_set[utd_pkg::E_RATE] = (rate_reg < utd_pkg::RATE_CDMA_MIN); // R04
        err_set[utd_pkg::E_PRES] = (seen_reg != 4'hF); // R21
      end else begin
        err_set[utd_pkg::E_PRES] = (seen_reg != 4'h0); // R21
      end
      if (seen_reg[1] && seen_reg[2] && (cpm_reg != 8'h00) && ((act_reg % cpm_reg) != 8'h00)) begin
        err_set[utd_pkg::E_MULT] = 1'b1; // R18
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      err_reg <= '0;
    end else begin
      err_reg <= (err_reg & ~err_clr) | err_set; // R24
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      done_pend_reg <= 1'b0;
      done_reg <= 1'b0;
      gen2_reg <= 1'b0;
      hop_reg <= 1'b0;
    end else begin
      done_pend_reg <= msg_end;
      done_reg <= done_pend_reg;
      gen2_reg <= (rate_reg == utd_pkg::RATE_GEN2) || cdma_reg; // R03 R13
      hop_reg <= cdma_reg && (seed_raw_reg[15:1] != 15'h0); // R20
    end
  end

  assign msg_done_out = done_reg;
  assign gen2_only_out = gen2_reg;
  assign sync_cdma_out = cdma_reg;
  assign hopping_on_out = hop_reg;
  assign error_out = |err_reg;

  // Address and data are taken together; the bus allows the slave to wait for both.
  assign aw_word = {s_axi_awaddr_in[8:2], 2'b00};
  assign ar_word = {s_axi_araddr_in[8:2], 2'b00};
  assign wr_fire = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_reg;
  assign s_axi_awready_out = wr_fire;
  assign s_axi_wready_out = wr_fire;
  assign err_clr = (wr_fire && (aw_word == utd_pkg::A_ERR) && s_axi_wstrb_in[0]) ? s_axi_wdata_in[6:0] : '0;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= utd_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= mapped(aw_word) ? utd_pkg::RESP_OKAY : utd_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      en_reg <= utd_pkg::CTRL_EN_RST;
    end else if (wr_fire && (aw_word == utd_pkg::A_CTRL) && s_axi_wstrb_in[0]) begin
      en_reg <= s_axi_wdata_in[0];
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (ar_word)
      utd_pkg::A_CTRL: rd_word[0] = en_reg;
      utd_pkg::A_STATUS: rd_word = {b2_cnt_reg, b1_cnt_reg, tot_len, 4'h0, error_out, hop_reg, cdma_reg, gen2_reg};
      utd_pkg::A_RATE: rd_word[7:0] = rate_reg;
      utd_pkg::A_FREQ: rd_word = freq_reg;
      utd_pkg::A_CDMA: rd_word[23:0] = {act_reg, cpm_reg, frame_reg};
      utd_pkg::A_SEED: rd_word[14:0] = seed_raw_reg[15:1]; // R19
      utd_pkg::A_ERR: rd_word[6:0] = err_reg;
      default: begin
        if (mapped(ar_word)) begin
          rd_word = {pre_byte(ar_word[7:0]), pre_byte(ar_word[7:0] | 8'h01),
                     pre_byte(ar_word[7:0] | 8'h02), pre_byte(ar_word[7:0] | 8'h03)}; // R07 R08
        end
      end
    endcase
  end

  assign ar_fire = s_axi_arvalid_in && !rvalid_reg;
  assign s_axi_arready_out = !rvalid_reg;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= utd_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= mapped(ar_word) ? utd_pkg::RESP_OKAY : utd_pkg::RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  property p_rate_legal;
    rate_reg inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
  endproperty
  a_rate_legal: assert property (p_rate_legal) else $error("Stored rate multiple is not legal."); // R02
  property p_gen2_rate;
    (rate_reg == 8'h20) |=> gen2_only_out;
  endproperty
  a_gen2_rate: assert property (p_gen2_rate) else $error("Rate 32 did not mark second generation."); // R03
  property p_gen2_cdma;
    cdma_reg |=> gen2_only_out;
  endproperty
  a_gen2_cdma: assert property (p_gen2_cdma) else $error("Code division did not mark second generation."); // R13
  property p_freq;
    (wr_val && (type_reg == utd_pkg::T_FREQ)) |=> (freq_reg[7:0] == $past(strm_data_in));
  endproperty
  a_freq: assert property (p_freq) else $error("Frequency byte not shifted in."); // R05
  property p_pre_msb;
    (wr_val && (type_reg == utd_pkg::T_PRE)) |=> (pre_mem[$past(cnt_reg)] == $past(strm_data_in));
  endproperty
  a_pre_msb: assert property (p_pre_msb) else $error("Preamble byte stored at wrong place."); // R07
  property p_ext;
    (wr_val && (type_reg == utd_pkg::T_PRE_EXT)) |=> (pre_mem[8'(8'h80 + $past(cnt_reg))] == $past(strm_data_in));
  endproperty
  a_ext: assert property (p_ext) else $error("Extension byte not stored after byte 128."); // R10
  property p_mode_default;
    (take && strm_first_in) |=> !sync_cdma_out;
  endproperty
  a_mode_default: assert property (p_mode_default) else $error("New message did not default to time division."); // R14
  property p_hop_off;
    (seed_raw_reg[15:1] == 15'h0) |=> !hopping_on_out;
  endproperty
  a_hop_off: assert property (p_hop_off) else $error("Zero seed left hopping on."); // R20
  property p_skip;
    (is_val && (type_reg > utd_pkg::T_SEED)) |=> ($stable(rate_reg) && $stable(freq_reg) && $stable(cdma_reg));
  endproperty
  a_skip: assert property (p_skip) else $error("Unknown parameter disturbed decoded values."); // R23
  property p_len_err;
    (is_len && !len_ok) |=> err_reg[0] ##1 err_reg[0];
  endproperty
  a_len_err: assert property (p_len_err) else $error("Length mismatch not held as error."); // R24
  property p_err_sticky;
    (error_out && (err_clr == 7'h00)) |=> error_out;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("Error dropped without a clear."); // R24
endmodule : utd_decoder
`default_nettype wire

// ==== test/utd_head_model.sv ====
// Headend model that streams parameter bytes of one descriptor message.
`timescale 1ns/100ps
`default_nettype none
module utd_head_model (
  input wire logic clk_sys_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [7:0] data_out,
  output logic first_out,
  output logic last_out
);
  logic [7:0] msg_q[$];
  logic stall_seen = 1'b0;
  initial begin
    valid_out = 1'b0;
    data_out = 8'h00;
    first_out = 1'b0;
    last_out = 1'b0;
  end
  // Idle data is inverted so a stale byte is never mistaken for a fresh one.
  task automatic send(input int gap);
    int k;
    for (int i = 0; i < msg_q.size(); i++) begin
      valid_out <= 1'b1;
      data_out <= msg_q[i];
      first_out <= (i == 0);
      last_out <= (i == msg_q.size() - 1);
      k = 0;
      do begin
        @(posedge clk_sys_in);
        k++;
      end while (!ready_in && k < 300);
      if (!ready_in) stall_seen = 1'b1;
      if (gap > 0 || i == msg_q.size() - 1) begin
        valid_out <= 1'b0;
        data_out <= ~msg_q[i];
        first_out <= 1'b0;
        last_out <= 1'b0;
      end
      // No gap after the last byte, so the done pulse is still ahead of the caller.
      if (i < msg_q.size() - 1) repeat (gap) @(posedge clk_sys_in);
      #1;
    end
    msg_q.delete();
  endtask : send
endmodule : utd_head_model
`default_nettype wire

// ==== test/utd_decoder_tb_top.sv ====
// Self-checking bench for the channel parameter decoder.
`timescale 1ns/100ps
`default_nettype none
module utd_decoder_tb_top;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic rdy, vld, fst, lst, done, gen2, cdma, hop, err, awr, wr, bv, arr, rv;
  logic [7:0] dat;
  logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  logic [8:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 4'hf;
  logic [1:0] br, rr;
  logic [31:0] cap_d;
  logic [1:0] cap_r;
  int fail_count = 0;
  int comparisons = 0;
  // Model slots: rate, freq, frame, codes, active, seed, cdma, err, type4, type5, presence, burst seen.
  int m[12];
  int rates[6] = '{1, 2, 4, 8, 16, 32};
  logic [7:0] pre[$];
  always #50 clk_sys_in = ~clk_sys_in;
  utd_head_model head_u (.clk_sys_in(clk_sys_in), .ready_in(rdy), .valid_out(vld), .data_out(dat),
    .first_out(fst), .last_out(lst));
  utd_decoder dut_u (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .strm_valid_in(vld), .strm_data_in(dat),
    .strm_first_in(fst), .strm_last_in(lst), .strm_ready_out(rdy), .msg_done_out(done), .gen2_only_out(gen2),
    .sync_cdma_out(cdma), .hopping_on_out(hop), .error_out(err), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rr));
  task automatic tick;
    @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic give_verdict;
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_for(input int w);
    int k;
    logic hit;
    k = 0;
    hit = 1'b0;
    // Handshakes are read at the edge itself, before that edge's register updates land.
    while (!hit && k < 300) begin
      @(posedge clk_sys_in);
      hit = (w == 0) ? (awr && wr) : (w == 1) ? bv : (w == 2) ? arr : (w == 3) ? rv : done;
      cap_d = rd;
      cap_r = (w == 1) ? br : rr;
      k++;
    end
    if (hit) begin
      #1;
    end else begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_for
  task automatic axi_wr(input logic [8:0] a, input logic [31:0] d, output logic [1:0] r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    wait_for(0);
    awv <= 1'b0;
    wv <= 1'b0;
    wait_for(1);
    r = cap_r;
    brdy <= 1'b0;
    tick();
  endtask : axi_wr
  task automatic axi_rd(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    wait_for(2);
    arv <= 1'b0;
    wait_for(3);
    d = cap_d;
    r = cap_r;
    rrdy <= 1'b0;
    tick();
  endtask : axi_rd
  task automatic rd_chk(input string nm, input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(nm, d, exp);
    chk("rresp", r, utd_pkg::RESP_OKAY);
  endtask : rd_chk
  task automatic rng(input int k, input int n, input int v, input int lo, input int hi);
    if (n != 1) m[7] |= 1;
    else if (v >= lo && v <= hi) m[k] = v;
    else m[7] |= 2;
  endtask : rng
  task automatic add(input int t, input int n, input logic [31:0] v);
    head_u.msg_q.push_back(t[7:0]);
    head_u.msg_q.push_back(n[7:0]);
    for (int i = n - 1; i >= 0; i--) head_u.msg_q.push_back(v[8 * i +: 8]);
    if (m[11] != 0 && t < 12 && t != 4 && t != 5) m[7] |= 32;
    m[8] += (t == 4);
    m[9] += (t == 5);
    if (t == 4 || t == 5) m[11] = 1;
    if (t >= 8 && t <= 11) m[10] |= 1 << (t - 8);
    case (t)
      1: if (n != 1) m[7] |= 1; else if (v inside {1, 2, 4, 8, 16, 32}) m[0] = v; else m[7] |= 2;
      2: if (n != 4) m[7] |= 1; else m[1] = v;
      7: if (n != 1) m[7] |= 1; else if (v == 1 || v == 2) m[6] = (v == 1); else m[7] |= 2;
      8: rng(2, n, v, 1, 32);
      9: rng(3, n, v, 2, 32);
      10: rng(4, n, v, 64, 128);
      11: if (n != 2) m[7] |= 1; else m[5] = v[15:1];
      default: ;
    endcase
  endtask : add
  task automatic pre_add(input int t, input int n);
    logic [7:0] b;
    logic ok;
    ok = (t == 3 || pre.size() == 128);
    if (!ok) m[7] |= 1;
    head_u.msg_q.push_back(t[7:0]);
    head_u.msg_q.push_back(n[7:0]);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      head_u.msg_q.push_back(b);
      if (ok) pre.push_back(b);
    end
  endtask : pre_add
  function automatic logic [31:0] word(input int w);
    word = 0;
    for (int i = 0; i < 4; i++) if (4 * w + i < pre.size()) word[31 - 8 * i -: 8] = pre[4 * w + i];
  endfunction : word
  task automatic clr;
    m = '{default: 0};
    pre.delete();
  endtask : clr
  task automatic run(input int gap);
    int g2, hp;
    logic [1:0] r;
    if (m[6] != 0) begin
      if (!(m[0] inside {8, 16, 32})) m[7] |= 4;
      if (m[10] != 15) m[7] |= 16;
    end else if (m[10] != 0) m[7] |= 16;
    if (m[3] != 0 && m[4] != 0 && m[4] % m[3] != 0) m[7] |= 8;
    g2 = (m[0] == 32 || m[6] != 0);
    hp = (m[6] != 0 && m[5] != 0);
    head_u.send(gap);
    wait_for(4);
    chk("gen2", gen2, g2);
    chk("cdma", cdma, m[6]);
    chk("hop", hop, hp);
    chk("stall", head_u.stall_seen, 1'b0);
    chk("error", err, m[7] != 0);
    rd_chk("rate", utd_pkg::A_RATE, m[0]);
    rd_chk("freq", utd_pkg::A_FREQ, m[1]);
    rd_chk("codes", utd_pkg::A_CDMA, (m[4] << 16) | (m[3] << 8) | m[2]);
    rd_chk("seed", utd_pkg::A_SEED, m[5]);
    rd_chk("errreg", utd_pkg::A_ERR, m[7]);
    rd_chk("status", utd_pkg::A_STATUS, (m[9] << 24) | (m[8] << 16) | (pre.size() << 8) | ((m[7] != 0) << 3)
      | (hp << 2) | (m[6] << 1) | g2);
    rd_chk("pre0", utd_pkg::A_PRE, word(0));
    rd_chk("pre32", utd_pkg::A_PRE + 9'h080, word(32));
    axi_wr(utd_pkg::A_ERR, 32'h0000_007f, r);
    chk("errclr", err, 1'b0);
  endtask : run
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    fail_count++;
    give_verdict();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'h96c0));
    repeat (10) tick();
    reset_in <= 1'b0;
    tick();
    rd_chk("ctrl", utd_pkg::A_CTRL, 1);
    // Stream refusal while disabled, then unmapped accesses on both channels.
    axi_wr(utd_pkg::A_CTRL, 0, r);
    chk("ready", rdy, 1'b0);
    axi_wr(utd_pkg::A_CTRL, 1, r);
    axi_rd(9'h020, d, r);
    chk("unmapped rd", d, 32'h0000_0000);
    chk("unmapped rresp", r, utd_pkg::RESP_SLVERR);
    axi_wr(9'h020, 1, r);
    chk("unmapped wr", r, utd_pkg::RESP_SLVERR);
    foreach (rates[i]) begin
      clr();
      add(1, 1, rates[i]);
      run(0);
    end
    clr();
    add(1, 1, 32);
    add(2, 4, $urandom);
    pre_add(3, 128);
    pre_add(6, 4);
    add(8'h30, 3, $urandom);
    add(4, 2, $urandom);
    add(5, 3, $urandom);
    add(4, 1, 0);
    run(2);
    clr();
    add(1, 1, 16);
    add(7, 1, 1);
    add(8, 1, 32);
    add(9, 1, 2);
    add(10, 1, 128);
    add(11, 2, $urandom | 2);
    pre_add(3, 5);
    add(5, 2, 0);
    run(0);
    clr();
    add(1, 1, 8);
    add(7, 1, 1);
    add(8, 1, 1);
    add(9, 1, 4);
    add(10, 1, 66);
    add(11, 2, 1);
    pre_add(3, 1);
    run(1);
    clr();
    add(1, 2, 8);
    add(1, 1, 3);
    add(7, 1, 2);
    add(8, 1, 4);
    add(7, 1, 9);
    add(10, 1, 200);
    pre_add(3, 10);
    pre_add(6, 2);
    run(0);
    clr();
    add(1, 1, 4);
    add(7, 1, 1);
    add(8, 1, 8);
    add(9, 1, 32);
    add(10, 1, 64);
    add(11, 2, 0);
    add(4, 1, 0);
    add(7, 1, 1);
    head_u.msg_q.push_back(8'h0c);
    m[7] |= 64;
    run(0);
    give_verdict();
  end
endmodule : utd_decoder_tb_top
`default_nettype wire
